// ### dcif_defines.vh
// Constants for the dual-core interrupt flag and deep idle block
`ifndef DCIF_DEFINES_VH
`define DCIF_DEFINES_VH

`define DCIF_ADDR_FLAGS     12'h000
`define DCIF_ADDR_MASK      12'h004
`define DCIF_ADDR_BSWITCH   12'h008
`define DCIF_ADDR_IDLE      12'h00C
`define DCIF_ADDR_SELECT    12'h010
`define DCIF_ADDR_IRQ_STAT  12'h014
`define DCIF_ADDR_IRQ_MASK  12'h018

`define DCIF_BIT_CORE_REQ   14
`define DCIF_BIT_DMA5       13
`define DCIF_BIT_DMA4       12
`define DCIF_BIT_SH11       11
`define DCIF_BIT_SH10       10
`define DCIF_BIT_HOST       9
`define DCIF_BIT_SH7        7
`define DCIF_BIT_SH6        6
`define DCIF_BIT_SER0_TX    5
`define DCIF_BIT_SER0_RX    4
`define DCIF_BIT_TIMER      3
`define DCIF_BIT_EXT1       1
`define DCIF_BIT_EXT0       0

`define DCIF_IMPL_BITS      16'h7EFB
`define DCIF_FLAGS_RESET    16'h0000
`define DCIF_MASK_RESET     16'h0000
`define DCIF_SELECT_RESET   4'h0

`define DCIF_EV_CORE_REQ    0
`define DCIF_EV_ALL_IDLE    1
`define DCIF_EV_WAKE        2

`endif

// ### dcif_irq_flags.v
// Interrupt flags, mask, core request and deep idle coordination
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "dcif_defines.vh"

module dcif_irq_flags (
	input  wire        mclk,
	input  wire        srst,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        peer_request,
	input  wire        dma_ch5_event,
	input  wire        dma_ch4_event,
	input  wire        dma_ch3_event,
	input  wire        dma_ch2_event,
	input  wire        dma_ch1_event,
	input  wire        dma_ch0_event,
	input  wire        serial1_tx_event,
	input  wire        serial1_rx_event,
	input  wire        serial2_tx_event,
	input  wire        serial2_rx_event,
	input  wire        serial0_tx_event,
	input  wire        serial0_rx_event,
	input  wire        host_port_event,
	input  wire        timer_event,
	input  wire        ext_pin0_event,
	input  wire        ext_pin1_event,
	input  wire        core_idle_enter,
	input  wire        peer_idle,
	input  wire        wake_event,
	output reg         core_to_core_request,
	output reg         self_idle,
	output reg         clocks_stopped,
	output reg  [15:0] core_pending,
	output wire        core_irq,
	output wire        irq
);

	reg  [15:0] interrupt_pending_flags;
	reg  [15:0] interrupt_enable_mask;
	reg  [3:0]  source_select;
	reg  [2:0]  irq_status;
	reg  [2:0]  irq_mask;
	reg  [31:0] rdata;
	reg         request_armed;
	reg  [15:0] raw_events;
	reg  [15:0] next_flags;
	reg  [2:0]  next_status;

	wire        acc      = psel & penable;
	wire        wr       = acc & pwrite;
	wire        both_idle = self_idle & peer_idle;

	function decoded;
		input [11:0] a;
		begin
			decoded = (a == `DCIF_ADDR_FLAGS) || (a == `DCIF_ADDR_MASK) ||
				(a == `DCIF_ADDR_BSWITCH) || (a == `DCIF_ADDR_IDLE) ||
				(a == `DCIF_ADDR_SELECT) || (a == `DCIF_ADDR_IRQ_STAT) ||
				(a == `DCIF_ADDR_IRQ_MASK);
		end
	endfunction

	function pick;
		input sel;
		input dma_ev;
		input ser_ev;
		begin
			pick = sel ? dma_ev : ser_ev;
		end
	endfunction

	assign pready  = 1'b1;
	assign pslverr = acc & ~decoded(paddr);
	assign prdata  = rdata;

	////////////////////////////////////////////////////////////////////////
	// Event mapping
	always @* begin
		raw_events                       = 16'h0000;
		raw_events[`DCIF_BIT_CORE_REQ]   = peer_request;
		raw_events[`DCIF_BIT_DMA5]       = dma_ch5_event;
		raw_events[`DCIF_BIT_DMA4]       = dma_ch4_event;
		raw_events[`DCIF_BIT_SH11]       = pick(source_select[3], dma_ch3_event,
			serial1_tx_event);
		raw_events[`DCIF_BIT_SH10]       = pick(source_select[2], dma_ch2_event,
			serial1_rx_event);
		raw_events[`DCIF_BIT_HOST]       = host_port_event;
		raw_events[`DCIF_BIT_SH7]        = pick(source_select[1], dma_ch1_event,
			serial2_tx_event);
		raw_events[`DCIF_BIT_SH6]        = pick(source_select[0], dma_ch0_event,
			serial2_rx_event);
		raw_events[`DCIF_BIT_SER0_TX]    = serial0_tx_event;
		raw_events[`DCIF_BIT_SER0_RX]    = serial0_rx_event;
		raw_events[`DCIF_BIT_TIMER]      = timer_event;
		raw_events[`DCIF_BIT_EXT1]       = ext_pin1_event;
		raw_events[`DCIF_BIT_EXT0]       = ext_pin0_event;
	end

	////////////////////////////////////////////////////////////////////////
	// Flag register: write one clears, a new event wins over the clear
	always @* begin
		next_flags = interrupt_pending_flags;
		if (wr && paddr == `DCIF_ADDR_FLAGS)
			next_flags = next_flags & ~pwdata[15:0];
		next_flags = (next_flags | raw_events) & `DCIF_IMPL_BITS;
	end

	always @* begin
		next_status = irq_status;
		if (wr && paddr == `DCIF_ADDR_IRQ_STAT)
			next_status = next_status & ~pwdata[2:0];
		next_status[`DCIF_EV_ALL_IDLE] = next_status[`DCIF_EV_ALL_IDLE] | (both_idle & ~clocks_stopped);
		next_status[`DCIF_EV_WAKE]     = next_status[`DCIF_EV_WAKE] | (clocks_stopped & wake_event);
		next_status[`DCIF_EV_CORE_REQ] = next_status[`DCIF_EV_CORE_REQ] |
			(wr && paddr == `DCIF_ADDR_BSWITCH && pwdata[0] && request_armed);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always @(posedge mclk) begin
		if (srst) begin
			interrupt_pending_flags <= `DCIF_FLAGS_RESET;
			interrupt_enable_mask   <= `DCIF_MASK_RESET;
			source_select           <= `DCIF_SELECT_RESET;
			irq_status              <= 3'h0;
			irq_mask                <= 3'h0;
			core_to_core_request    <= 1'b0;
			request_armed           <= 1'b1;
			self_idle               <= 1'b0;
			clocks_stopped          <= 1'b0;
			core_pending            <= 16'h0000;
			rdata                   <= 32'h0000_0000;
		end else begin
			interrupt_pending_flags <= next_flags;
			irq_status              <= next_status;
			core_pending            <= next_flags & interrupt_enable_mask;
			core_to_core_request    <= 1'b0;
			if (wr) begin
				case (paddr)
				`DCIF_ADDR_MASK: begin
					interrupt_enable_mask <= pwdata[15:0] & `DCIF_IMPL_BITS;
				end
				`DCIF_ADDR_BSWITCH: begin
					// Pulse once per 0-to-1 of the field; re-arm only on 0
					if (pwdata[0] && request_armed) begin
						core_to_core_request <= 1'b1;
						request_armed        <= 1'b0;
					end else if (!pwdata[0]) begin
						request_armed <= 1'b1;
					end
				end
				`DCIF_ADDR_SELECT: begin
					source_select <= pwdata[3:0];
				end
				`DCIF_ADDR_IRQ_MASK: begin
					irq_mask <= pwdata[2:0];
				end
				default: begin
				end
				endcase
			end
			// Idle entry from either core in any order
			if (core_idle_enter)
				self_idle <= 1'b1;
			if (both_idle && !wake_event)
				clocks_stopped <= 1'b1;
			if (wake_event) begin
				clocks_stopped <= 1'b0;
				self_idle      <= 1'b0;
			end
			if (psel && !penable && !pwrite) begin
				case (paddr)
				`DCIF_ADDR_FLAGS:    rdata <= {16'h0000, interrupt_pending_flags};
				`DCIF_ADDR_MASK:     rdata <= {16'h0000, interrupt_enable_mask};
				`DCIF_ADDR_BSWITCH:  rdata <= {31'h0000_0000, ~request_armed};
				`DCIF_ADDR_IDLE:     rdata <= {29'h0000_0000, clocks_stopped, peer_idle, self_idle};
				`DCIF_ADDR_SELECT:   rdata <= {28'h000_0000, source_select};
				`DCIF_ADDR_IRQ_STAT: rdata <= {29'h0000_0000, irq_status};
				`DCIF_ADDR_IRQ_MASK: rdata <= {29'h0000_0000, irq_mask};
				default:             rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Core sees only pending and enabled sources
	assign core_irq = |core_pending;
	assign irq      = |(irq_status & irq_mask);

endmodule // dcif_irq_flags

// ### dcif_src_model.sv
// Peripheral side: routes each request to its serial or DMA source
module dcif_src_model (
	input  wire logic        use_dma,
	input  wire logic [15:0] fire,
	output logic      [15:0] ser_ev,
	output logic      [15:0] dma_ev
);
	timeunit 1ns;
	timeprecision 1ps;
	// Only one of a shared pair fires, as the chosen peripheral would
	assign ser_ev = use_dma ? 16'h0000 : fire;
	assign dma_ev = use_dma ? fire : 16'h0000;
endmodule // dcif_src_model

// ### dcif_irq_flags_asserts.sv
// Port-level checks for the interrupt flag block
module dcif_irq_flags_asserts (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        core_idle_enter,
	input wire logic        peer_idle,
	input wire logic        wake_event,
	input wire logic        self_idle,
	input wire logic        clocks_stopped,
	input wire logic        core_to_core_request,
	input wire logic [15:0] core_pending
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire acc = psel && penable;
	wire wr_req = acc && pwrite && paddr == 12'h008 && pwdata[0];
	wire fl_wr = acc && pwrite && (paddr == 12'h000 || paddr == 12'h004);
	sequence s_both; self_idle && peer_idle && !wake_event; endsequence
	property p_enter; core_idle_enter && !wake_event |=> self_idle; endproperty
	a_enter: assert property (p_enter) else $error("idle entry missed");
	property p_stop; s_both |=> clocks_stopped; endproperty
	a_stop: assert property (p_stop) else $error("clocks not stopped");
	property p_early; $rose(clocks_stopped) |-> $past(self_idle && peer_idle); endproperty
	a_early: assert property (p_early) else $error("early clock stop");
	property p_req_one; core_to_core_request |=> !core_to_core_request; endproperty
	a_req_one: assert property (p_req_one) else $error("request too long");
	property p_req_cause; $rose(core_to_core_request) |-> $past(wr_req) || $past(wr_req, 2); endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without write");
	property p_resv; (core_pending & 16'h8104) == 16'h0000; endproperty
	a_resv: assert property (p_resv) else $error("reserved bit pending");
	property p_sticky; core_pending[0] && !fl_wr |=> core_pending[0]; endproperty
	a_sticky: assert property (p_sticky) else $error("pending bit lost");
	property p_err; acc && paddr > 12'h018 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
endmodule // dcif_irq_flags_asserts

bind dcif_irq_flags dcif_irq_flags_asserts chk (.*);

// ### test_dcif_irq_flags.sv
// Self-checking bench for the interrupt flag block
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_dcif_irq_flags;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, dsel = 0, err;
	logic core_idle_enter = 0, peer_idle = 0, wake_event = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [15:0] fire = 16'h0000, e, sv, dv, core_pending;
	wire [31:0] prdata;
	wire pready, pslverr, core_to_core_request, self_idle, clocks_stopped, core_irq, irq;
	int n_fail = 0, comparisons = 0, cyc = 0, npul = 0;
	dcif_src_model src (.use_dma(dsel), .fire(fire), .ser_ev(sv), .dma_ev(dv));
	dcif_irq_flags uut (.*, .peer_request(sv[14]), .dma_ch5_event(dv[13]), .dma_ch4_event(dv[12]),
		.dma_ch3_event(dv[11]), .dma_ch2_event(dv[10]), .dma_ch1_event(dv[7]), .dma_ch0_event(dv[6]),
		.serial1_tx_event(sv[11]), .serial1_rx_event(sv[10]), .serial2_tx_event(sv[7]),
		.serial2_rx_event(sv[6]), .serial0_tx_event(sv[5]), .serial0_rx_event(sv[4]),
		.host_port_event(sv[9]), .timer_event(sv[3]), .ext_pin1_event(sv[1]), .ext_pin0_event(sv[0]));
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (core_to_core_request === 1'b1) npul <= npul + 1;
		// Hang guard, well above the expected run
		if (cyc == 5000) begin
			n_fail++;
			test_done;
		end
	end
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] x);
		bus(0, a, 32'h0);
		`CK(n, x, rd)
	endtask
	task automatic pulse(input logic [15:0] f);
		@(posedge mclk) fire <= f;
		@(posedge mclk) fire <= 16'h0000;
		@(posedge mclk);
	endtask
	task test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		srst <= 0;
		rchk("flags", 12'h000, 32'h0);
		bus(1, 12'h004, 32'hFFFFFFFF);
		rchk("mask", 12'h004, 32'h7EFB);
		// Pass 0 serial sources, pass 1 DMA sources on shared bits
		for (int p = 0; p < 2; p++) begin
			bus(1, 12'h010, p ? 32'hF : 32'h0);
			dsel <= p[0];
			for (int i = 0; i < 16; i++) begin
				e = (16'h0001 << i) & (p ? 16'h3CC0 : 16'h4EFB);
				pulse(16'h0001 << i);
				`CK("core_irq", |e, core_irq)
				`CK("pending", e, core_pending)
				rchk("flags", 12'h000, {16'h0000, e});
				bus(1, 12'h000, 32'hFFFF);
			end
		end
		bus(1, 12'h010, 32'h0);
		pulse(16'h0800);
		rchk("flags", 12'h000, 32'h0);
		dsel <= 0;
		bus(1, 12'h004, 32'h0);
		pulse(16'h0008);
		`CK("core_irq", 1'b0, core_irq)
		rchk("flags", 12'h000, 32'h8);
		bus(1, 12'h018, 32'h7);
		bus(1, 12'h008, 32'h1);
		bus(1, 12'h008, 32'h1);
		repeat (3) @(posedge mclk);
		`CK("pulses", 1, npul)
		`CK("irq", 1'b1, irq)
		bus(1, 12'h014, 32'h1);
		bus(1, 12'h008, 32'h0);
		bus(1, 12'h008, 32'h1);
		repeat (3) @(posedge mclk);
		`CK("pulses", 2, npul)
		bus(1, 12'h014, 32'h1);
		@(posedge mclk);
		`CK("irq", 1'b0, irq)
		pulse(16'h0000);
		@(posedge mclk) core_idle_enter <= 1;
		@(posedge mclk) core_idle_enter <= 0;
		repeat (3) @(posedge mclk);
		`CK("stopped", 1'b0, clocks_stopped)
		peer_idle <= 1;
		repeat (3) @(posedge mclk);
		`CK("stopped", 1'b1, clocks_stopped)
		wake_event <= 1;
		@(posedge mclk) wake_event <= 0;
		repeat (2) @(posedge mclk);
		`CK("stopped", 1'b0, clocks_stopped)
		`CK("self_idle", 1'b0, self_idle)
		core_idle_enter <= 1;
		@(posedge mclk) core_idle_enter <= 0;
		repeat (3) @(posedge mclk);
		`CK("stopped", 1'b1, clocks_stopped)
		`CK("self_idle", 1'b1, self_idle)
		rchk("stat", 12'h014, 32'h6);
		bus(0, 12'h01C, 32'h0);
		`CK("slverr", 1'b1, err)
		test_done;
	end
endmodule // test_dcif_irq_flags
